// File: src/bus_address_vector_decode.sv
`timescale 1ns/1ps
`include "bus_address_vector_decode_map.svh"
// How it works
// - respond only when address matches switch bits
// - address bits 15..13 always decode as ones
// - low address bits select register, csr bytes
// - vector bits 7..3 come from switches
// - vector bit 2 on end-of-range, 1..0 zero
// - increment mux channel after each conversion
// - default base 177000, vector 130 octal
// - external trigger starts conversion when enabled
// - twelve-bit word count raises end-of-range on overflow
// - bus initialize clears control/status register
module bus_address_vector_decode (
    // clock and reset
    input  wire logic                                  clock_i,
    input  wire logic                                  rst_i,
    // host bus
    input  wire bus_address_vector_decode_pkg::bus_req_t bus_i,
    input  wire logic                                  bus_init_i,
    output logic [15:0]                                bus_rdata_o,
    output logic                                       bus_rdata_oe_n_o,
    output logic                                       bus_reply_o,
    // interrupt
    input  wire logic                                  irq_ack_i,
    output logic                                       irq_o,
    output logic [7:0]                                 vector_o,
    // switches, open switch reads as one
    input  wire logic [12:3]                           address_switch_bank_i,
    input  wire logic [7:3]                            vector_switch_bank_i,
    // converter side
    input  wire logic                                  trigger_i,
    input  wire logic [15:0]                           conv_result_i,
    input  wire logic                                  dma_transfer_done_i,
    output logic                                       start_conv_o,
    output logic [5:0]                                 mux_channel_o,
    output logic [15:0]                                dma_address_o
);
    // ****************************************
    // state registers
    // ****************************************
    // the whole block state is one packed struct
    bus_address_vector_decode_pkg::state_t s_q;  // registered state
    bus_address_vector_decode_pkg::state_t s_d;  // next state
    logic hit;                                   // address match
    logic [1:0] sel;                             // register select
    logic trig_rise;                             // synced trigger edge
    logic conv_end;                              // conversion finished

    // ****************************************
    // next state logic
    // ****************************************
    // one process computes every next value; pulses default inactive each cycle
    always_comb begin
        // hold everything unless a branch below changes it
        s_d = s_q;
        // reply and data drive last one cycle only
        s_d.reply = 1'b0;
        s_d.rdata_oe_n = 1'b1;
        s_d.start_conv = 1'b0;
        // trigger pin passes two flip-flops before the edge detector
        s_d.trig_sync = {s_q.trig_sync[0], trigger_i};
        s_d.trig_prev = s_q.trig_sync[1];
        // initialize is a level from another board, synced the same way
        s_d.init_sync = {s_q.init_sync[0], bus_init_i};
        // edge taken from the second stage only, so metastability never reaches it
        trig_rise = s_q.trig_sync[1] & ~s_q.trig_prev;
        // switch compare, top bits forced to one
        // default switch values live in the map header
        hit = bus_i.sync && (bus_i.addr[15:13] == 3'h7)
              && (bus_i.addr[12:3] == address_switch_bank_i);
        // word register select, byte lane handled at the write
        sel = bus_i.addr[2:1];
        conv_end = 1'b0;
        // converter sequencer: a fixed conversion time stands in for the analog module
        case (s_q.conv_state)
            // idle: the trigger enables choose between pin edge and start bit
            bus_address_vector_decode_pkg::conv_idle: begin
                if ((s_q.control_status[`CSR_EXTERNAL_BIT] ||
                     s_q.control_status[`CSR_PERIODIC_BIT]) ? trig_rise
                    : s_q.control_status[`CSR_START_BIT]) begin
                    s_d.conv_state = bus_address_vector_decode_pkg::conv_busy;
                    s_d.conv_count = 16'(`CONVERT_CYCLES);
                    s_d.start_conv = 1'b1;
                end
            end
            // busy: a start request here is ignored, and a start bit set now is retired when the count runs out
            default: begin
                // last busy cycle: the result is taken at the next edge
                if (s_q.conv_count == 16'h0001) begin
                    conv_end = 1'b1;
                    s_d.conv_state = bus_address_vector_decode_pkg::conv_idle;
                end else begin
                    // still converting, count down
                    s_d.conv_count = s_q.conv_count - 16'h0001;
                end
            end
        endcase
        // result latched, done raised, software start retired
        if (conv_end) begin
            s_d.data_buffer = conv_result_i;
            s_d.control_status[`CSR_DONE_BIT] = 1'b1;
            s_d.control_status[`CSR_START_BIT] = 1'b0;
            if (s_q.control_status[`CSR_INC_MODE_BIT]) begin
                s_d.control_status[`CSR_MUX_HI:`CSR_MUX_LO] =
                    s_q.control_status[`CSR_MUX_HI:`CSR_MUX_LO] + 6'h01;
            end
        end
        // dma transfer: count and address advance
        // the word count runs upward from the two's complement toward zero
        if (dma_transfer_done_i) begin
            // word addresses step by two bytes
            s_d.dma_memory_address = s_q.dma_memory_address + 16'h0002;
            // the transfer empties the buffer, but a fresh result keeps done set
            if (!conv_end) s_d.control_status[`CSR_DONE_BIT] = 1'b0;
            if (s_q.dma_word_count == 12'hfff) begin
                s_d.dma_done = 1'b1;
            end
            s_d.dma_word_count = s_q.dma_word_count + 12'h001;
        end
        // bus access, nothing when no hit
        // foreign addresses fall through: no reply, data lines stay released
        if (hit && (bus_i.read || bus_i.write)) begin
            s_d.reply = 1'b1;
            if (bus_i.read) begin
                // read: the word stands on the lines for exactly one cycle
                s_d.rdata_oe_n = 1'b0;
                if (sel == `REG_SEL_CONTROL_STATUS) begin
                    s_d.rdata = s_q.control_status;
                end else if (sel == `REG_SEL_DATA_BUFFER) begin
                    s_d.rdata = s_q.data_buffer;
                    // reading data clears done unless a new result lands now
                    if (!conv_end) s_d.control_status[`CSR_DONE_BIT] = 1'b0;
                end else if (sel == `REG_SEL_WORD_COUNT) begin
                    // count reads back with its upper four bits zero
                    s_d.rdata = {4'h0, s_q.dma_word_count};
                end else begin
                    s_d.rdata = s_q.dma_memory_address;
                end
            end else if (sel == `REG_SEL_CONTROL_STATUS) begin
                // byte lanes decoded only here, the other registers take whole words
                // low byte: done is read only, so bit 7 keeps its own value
                if (!bus_i.byte_op || !bus_i.addr[0]) begin
                    s_d.control_status[6:0] = bus_i.wdata[6:0];
                end
                // high byte: a byte write brings its data on the low lines
                if (!bus_i.byte_op || bus_i.addr[0]) begin
                    s_d.control_status[15:8] = bus_i.byte_op ? bus_i.wdata[7:0]
                                                              : bus_i.wdata[15:8];
                end
            end else if (sel == `REG_SEL_WORD_COUNT) begin
                // count is twelve bits wide, the upper lines are ignored
                s_d.dma_word_count = bus_i.wdata[11:0];
            end else if (sel == `REG_SEL_MEMORY_ADDRESS) begin
                s_d.dma_memory_address = bus_i.wdata;
            end
        end
        // interrupt: end-of-range wins over a normal request
        // the request level stands until acknowledged; vector frozen meanwhile
        if (s_q.dma_done && !s_q.irq) begin
            s_d.irq = 1'b1;
            s_d.vector = {vector_switch_bank_i, 3'h4};
        end else if (!s_q.irq && s_q.control_status[`CSR_INT_ENABLE_BIT] &&
                     (s_q.control_status[`CSR_DONE_BIT] ||
                      s_q.control_status[`CSR_ERROR_BIT])) begin
            s_d.irq = 1'b1;
            // normal request: done or error with interrupts on
            // bits 2..0 zero
            s_d.vector = {vector_switch_bank_i, 3'h0};
        end
        // acknowledge drops the request line
        if (s_q.irq && irq_ack_i) begin
            s_d.irq = 1'b0;
            // end-of-range clears itself on acknowledge, unless a new one lands now
            if (s_q.vector[2] && !(dma_transfer_done_i && s_q.dma_word_count == 12'hfff)) begin
                s_d.dma_done = 1'b0;
            end
        end
        // initialize also stops the converter and drops pending requests
        // initialize clears the control/status register
        if (s_q.init_sync[1]) begin
            s_d.control_status = `CSR_RESET;
            s_d.conv_state = bus_address_vector_decode_pkg::conv_idle;
            s_d.irq = 1'b0;
            s_d.dma_done = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // single register for all state, cleared at once by the async reset except rdata_oe_n, which is set
    always_ff @(posedge clock_i or posedge rst_i) begin
        // reset branch loads constants only
        if (rst_i) begin
            s_q <= '0;
            // data lines start released
            s_q.rdata_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs straight from flip-flops
    // ****************************************
    assign bus_rdata_o      = s_q.rdata;
    // no logic after the flip-flops, so no glitch reaches the bus
    assign bus_rdata_oe_n_o = s_q.rdata_oe_n;
    assign bus_reply_o      = s_q.reply;
    assign irq_o            = s_q.irq;
    assign vector_o         = s_q.vector;
    assign start_conv_o     = s_q.start_conv;
    // channel and dma address are views of the register copy
    assign mux_channel_o    = s_q.control_status[`CSR_MUX_HI:`CSR_MUX_LO];
    assign dma_address_o    = s_q.dma_memory_address;
endmodule : bus_address_vector_decode

// File: src/bus_address_vector_decode_map.svh
`ifndef BUS_ADDRESS_VECTOR_DECODE_MAP_SVH
`define BUS_ADDRESS_VECTOR_DECODE_MAP_SVH
// register select codes on address bits 2..1
`define REG_SEL_CONTROL_STATUS 2'h0
`define REG_SEL_DATA_BUFFER    2'h1
`define REG_SEL_WORD_COUNT     2'h2
`define REG_SEL_MEMORY_ADDRESS 2'h3
// control/status field positions
`define CSR_ERROR_BIT          15
`define CSR_INC_MODE_BIT       14
`define CSR_MUX_HI             13
`define CSR_MUX_LO             8
`define CSR_DONE_BIT           7
`define CSR_INT_ENABLE_BIT     6
`define CSR_PERIODIC_BIT       5
`define CSR_EXTERNAL_BIT       4
`define CSR_DMA_ENABLE_BIT     1
`define CSR_START_BIT          0
// writable mask of the control/status word (done is read only)
`define CSR_WRITE_MASK         16'hff7f
// reset values
`define CSR_RESET              16'h0000
`define WORD_COUNT_RESET       12'h000
`define MEMORY_ADDRESS_RESET   16'h0000
// default switch settings: base 177000 octal, vector 130 octal
`define ADDRESS_SWITCH_DEFAULT 10'h3c0
`define VECTOR_SWITCH_DEFAULT  5'h0b
// conversion time in ns and its cycle count at 100 MHz
`define CONVERT_TIME_NS        1000
`define CLOCK_PERIOD_NS        10
`define CONVERT_CYCLES         ((`CONVERT_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

// File: src/bus_address_vector_decode_pkg.sv
package bus_address_vector_decode_pkg;
    // one bus request as seen by the decoder
    typedef struct packed {
        logic        sync;
        logic [15:0] addr;
        logic        read;
        logic        write;
        logic        byte_op;
        logic [15:0] wdata;
    } bus_req_t;
    // converter state
    typedef enum logic [1:0] {conv_idle, conv_busy} conv_state_t;
    // all state of the block
    typedef struct packed {
        logic [15:0] control_status;
        logic [15:0] data_buffer;
        logic [11:0] dma_word_count;
        logic [15:0] dma_memory_address;
        logic [15:0] rdata;
        logic        rdata_oe_n;
        logic        reply;
        logic        irq;
        logic [7:0]  vector;
        logic        start_conv;
        logic [15:0] conv_count;
        conv_state_t conv_state;
        logic [1:0]  trig_sync;
        logic        trig_prev;
        logic [1:0]  init_sync;
        logic        dma_done;
    } state_t;
endpackage : bus_address_vector_decode_pkg

// File: verification/bus_address_vector_decode_props.sv
`timescale 1ns/1ps
// ****
// decode checker
// ****
module bus_address_vector_decode_props (
    input wire logic                                     clock_i,
    input wire logic                                     rst_i,
    input wire bus_address_vector_decode_pkg::bus_req_t bus_i,
    input wire logic                                     bus_rdata_oe_n_o,
    input wire logic                                     bus_reply_o,
    input wire logic                                     irq_o,
    input wire logic [7:0]                               vector_o,
    input wire logic [12:3]                              address_switch_bank_i,
    input wire logic [7:3]                               vector_switch_bank_i,
    input wire logic [5:0]                               mux_channel_o,
    input wire logic [15:0]                              dma_address_o
);
    logic hit; // request aimed at this block
    assign hit = bus_i.sync && (bus_i.read || bus_i.write) && (&bus_i.addr[15:13])
                 && (bus_i.addr[12:3] == address_switch_bank_i);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    AST_HIT_REPLY: assert property (hit |=> bus_reply_o) else $error("no reply");
    AST_TOP_BITS: assert property (bus_i.sync && !(&bus_i.addr[15:13]) |=> !bus_reply_o)
        else $error("reply with low top bits");
    AST_READ_DRIVE: assert property (hit && bus_i.read |=> !bus_rdata_oe_n_o)
        else $error("read not driven");
    AST_QUIET: assert property (!hit |=> !bus_reply_o && bus_rdata_oe_n_o)
        else $error("answer to foreign access");
    AST_REPLY_CAUSE: assert property (bus_reply_o |-> $past(hit)) else $error("stray reply");
    AST_VEC_SW: assert property (irq_o |-> vector_o[7:3] == vector_switch_bank_i)
        else $error("vector high bits");
    AST_VEC_LOW: assert property (irq_o |-> vector_o[1:0] == 2'b00)
        else $error("vector low bits");
    // channel moves by one unless the host wrote it or it was cleared
    AST_MUX_STEP: assert property ($changed(mux_channel_o) && !bus_reply_o
        && mux_channel_o != 6'h00 |-> mux_channel_o == $past(mux_channel_o) + 6'h01)
        else $error("mux step");
    AST_DMA_STEP: assert property ($changed(dma_address_o) && !bus_reply_o
        && dma_address_o != 16'h0000 |-> dma_address_o == $past(dma_address_o) + 16'h0002)
        else $error("dma step");
    C_READ: cover property (hit && bus_i.read);
    C_IRQ: cover property (irq_o && vector_o[2]);
    C_MUX: cover property ($changed(mux_channel_o) && !bus_reply_o);
endmodule : bus_address_vector_decode_props
bind bus_address_vector_decode bus_address_vector_decode_props u_props (
    .clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i), .bus_rdata_oe_n_o(bus_rdata_oe_n_o),
    .bus_reply_o(bus_reply_o), .irq_o(irq_o), .vector_o(vector_o),
    .address_switch_bank_i(address_switch_bank_i), .vector_switch_bank_i(vector_switch_bank_i),
    .mux_channel_o(mux_channel_o), .dma_address_o(dma_address_o));

// File: verification/host_model.sv
`timescale 1ns/1ps
// ****
// host bus master
// ****
module host_model (
    input  wire logic                              clock_i,
    input  wire logic [15:0]                       bus_rdata_o,
    input  wire logic                              bus_reply_o,
    output bus_address_vector_decode_pkg::bus_req_t bus_o
);
    initial bus_o = '0;
    // hold one taking edge, then scramble released lines so stale values never match
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] w,
                          output logic [15:0] r, output logic ok);
        @(posedge clock_i);
        bus_o <= '{1'b1, a, !wr, wr, 1'b0, w};
        @(posedge clock_i);
        bus_o <= '{1'b0, ~a, 1'b0, 1'b0, 1'b0, ~w};
        #1;
        r = bus_rdata_o;
        ok = bus_reply_o;
    endtask : access
endmodule : host_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "bus_address_vector_decode_map.svh"
// ****
// decode bench
// ****
module tb_top;
    localparam logic [15:0] BASE = 16'hfe00; // default base, 177000 octal
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        bus_init_i = 1'b0;
    logic        irq_ack_i = 1'b0;
    logic        trigger_i = 1'b0;
    logic        dma_done = 1'b0;
    logic [15:0] conv_res = 16'h0abc;
    logic [12:3] addr_sw = `ADDRESS_SWITCH_DEFAULT;
    logic [7:3]  vec_sw = `VECTOR_SWITCH_DEFAULT;
    logic [15:0] rdata, dma_addr, rd, v, a, m;
    logic        oe_n, reply, irq, start, ok;
    logic [7:0]  vec;
    logic [5:0]  mux;
    int          n_fail = 0;
    int          checks_done = 0;
    int          n_start = 0; // conversion start pulses seen
    bus_address_vector_decode_pkg::bus_req_t bus;
    always #5 clock_i = ~clock_i;
    // count start pulses so every conversion is accounted for
    always @(posedge clock_i)
        if (start === 1'b1) n_start <= n_start + 1;
    host_model u_host_model (.clock_i(clock_i), .bus_rdata_o(rdata), .bus_reply_o(reply),
        .bus_o(bus));
    bus_address_vector_decode u_bus_address_vector_decode (.clock_i(clock_i), .rst_i(rst_i),
        .bus_i(bus), .bus_init_i(bus_init_i), .bus_rdata_o(rdata), .bus_rdata_oe_n_o(oe_n),
        .bus_reply_o(reply), .irq_ack_i(irq_ack_i), .irq_o(irq), .vector_o(vec),
        .address_switch_bank_i(addr_sw), .vector_switch_bank_i(vec_sw), .trigger_i(trigger_i),
        .conv_result_i(conv_res), .dma_transfer_done_i(dma_done), .start_conv_o(start),
        .mux_channel_o(mux), .dma_address_o(dma_addr));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    // vector expected from switches plus end-of-range flag
    function automatic logic [7:0] vec_exp(input logic [7:3] sw, input logic end_of_range);
        return {sw, end_of_range, 2'b00};
    endfunction : vec_exp
    // write a word, then read it back with the data lines driven
    task automatic wr_rd(input logic [15:0] ad, input logic [15:0] w, output logic [15:0] r);
        u_host_model.access(1'b1, ad, w, r, ok);
        check({15'h0, ok}, 16'h0001);
        u_host_model.access(1'b0, ad, 16'h0, r, ok);
        check({15'h0, oe_n}, 16'h0000);
    endtask : wr_rd
    task automatic give_verdict;
        $display("fails %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        void'($urandom(32'h60f98243));
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        // random values through control/status, count and address
        for (int i = 0; i < 3; i++) begin
            v = $urandom;
            a = BASE | 16'(2 * i + (i > 0 ? 2 : 0));
            m = (i == 0) ? 16'h3f0c : (i == 1) ? 16'h0fff : 16'hffff;
            wr_rd(a, v & m, rd);
            check(rd & m, v & m & (i == 0 ? `CSR_WRITE_MASK : 16'hffff));
        end
        // one address bit off the base, top bits included
        for (int i = 0; i < 6; i++) begin
            a = BASE ^ (16'h0008 << ($urandom % 13));
            u_host_model.access(1'b0, a, 16'h0, rd, ok);
            check({14'h0, ok, oe_n}, 16'h0001);
        end
        // external trigger with channel increment
        wr_rd(BASE, 16'h4010, rd);
        trigger_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        trigger_i <= 1'b0;
        repeat (`CONVERT_CYCLES + 20) @(posedge clock_i);
        check({10'h0, mux}, 16'h0001);
        check(16'(n_start), 16'h0001);
        u_host_model.access(1'b0, BASE, 16'h0, rd, ok);
        check(rd, 16'h4190);
        u_host_model.access(1'b0, BASE | 16'h2, 16'h0, rd, ok);
        check(rd, conv_res);
        u_host_model.access(1'b0, BASE, 16'h0, rd, ok);
        check(rd, 16'h4110);
        // two-word block runs the count over
        wr_rd(BASE | 16'h4, 16'h0ffe, rd);
        wr_rd(BASE | 16'h6, 16'h1000, rd);
        wr_rd(BASE, 16'h0042, rd);
        repeat (2) begin
            dma_done <= 1'b1;
            @(posedge clock_i);
            dma_done <= 1'b0;
            repeat (3) @(posedge clock_i);
        end
        for (int k = 0; k < 40 && irq !== 1'b1; k++) @(posedge clock_i) #1;
        check({15'h0, irq}, 16'h0001);
        check({8'h0, vec}, {8'h0, vec_exp(vec_sw, 1'b1)});
        check({8'h0, vec}, 16'h005c);
        check(dma_addr, 16'h1004);
        @(posedge clock_i);
        irq_ack_i <= 1'b1;
        @(posedge clock_i);
        irq_ack_i <= 1'b0;
        @(posedge clock_i);
        check({15'h0, irq}, 16'h0000);
        // processor initialize
        bus_init_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        bus_init_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        u_host_model.access(1'b0, BASE, 16'h0, rd, ok);
        check(rd, `CSR_RESET);
        // software start with interrupts on: normal vector, bits 2..0 zero
        wr_rd(BASE, 16'h0041, rd);
        repeat (`CONVERT_CYCLES + 10) @(posedge clock_i);
        check(16'(n_start), 16'h0002);
        check({15'h0, irq}, 16'h0001);
        check({8'h0, vec}, {8'h0, vec_exp(vec_sw, 1'b0)});
        u_host_model.access(1'b0, BASE | 16'h2, 16'h0, rd, ok);
        check(rd, conv_res);
        @(posedge clock_i);
        irq_ack_i <= 1'b1;
        @(posedge clock_i);
        irq_ack_i <= 1'b0;
        @(posedge clock_i);
        check({15'h0, irq}, 16'h0000);
        give_verdict();
    end
    // watchdog, well beyond the expected run
    initial begin
        repeat (5000) @(posedge clock_i);
        n_fail++;
        give_verdict();
    end
endmodule : tb_top
